// file: core/discrete_signal_map.sv
`timescale 1ns/10ps
module discrete_signal_map
  import mgmt_access_pkg::*;
(
  input  wire logic reset_req_pin_i,
  input  wire logic lowpwr_req_pin_i,
  output logic      reset_req_o,
  output logic      lowpwr_req_o
);

  // Pin levels become asserted/deasserted here; polarity lives in the package
  assign reset_req_o  = (reset_req_pin_i == RESET_REQ_ACTIVE);   // see R2
  assign lowpwr_req_o = (lowpwr_req_pin_i == LOWPWR_REQ_ACTIVE); // see R2

endmodule : discrete_signal_map

// file: core/holdoff_timer.sv
`timescale 1ns/10ps
module holdoff_timer
  import mgmt_access_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic resetn_i,
  input  wire logic start_i,
  output logic      busy_o
);

  typedef struct packed {
    logic [HOLD_W-1:0] cnt;
  } hold_t;

  hold_t r;
  hold_t n;

  always_comb begin
    n = r;
    if (start_i) begin
      n.cnt = HOLD_W'(HOLDOFF_CYC); // see R23
    end else if (r.cnt != '0) begin
      n.cnt = r.cnt - HOLD_W'(1); // Releases on expiry, never longer, see R13
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign busy_o = (r.cnt != '0);

endmodule : holdoff_timer

// file: core/mgmt_access_pkg.sv
package mgmt_access_pkg;

  // Directly addressable management memory
  localparam int unsigned MEM_BYTES   = 256;
  localparam logic [7:0]  UPPER_FIRST = 8'h80;
  localparam logic [3:0]  MAX_LEN     = 4'h8;

  // Flag bytes (clear on read) and their interrupt masks
  localparam logic [7:0]  FLAG_FIRST  = 8'h08;
  localparam logic [7:0]  FLAG_LAST   = 8'h0f;
  localparam logic [7:0]  MASK_FIRST  = 8'h18;
  localparam int unsigned FLAG_COUNT  = 8;

  // Reset values
  localparam logic [7:0]  MEM_RESET       = 8'h00;
  localparam logic        LOW_POWER_RESET = 1'b1;

  // Physical level of the asserted state of each discrete signal
  localparam logic RESET_REQ_ACTIVE  = 1'b0;
  localparam logic LOWPWR_REQ_ACTIVE = 1'b1;
  localparam logic IRQ_ACTIVE        = 1'b0;

  // Access operations on the request port
  localparam logic [1:0] OP_READ  = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_TEST  = 2'h2;

  // Longest access hold-off after a write that reaches upper memory
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned HOLDOFF_MAX_NS = 500;
  localparam int unsigned HOLDOFF_CYC    = (HOLDOFF_MAX_NS / CLK_PERIOD_NS > 0) ?
                                           HOLDOFF_MAX_NS / CLK_PERIOD_NS : 1;
  localparam int unsigned HOLD_W         = 8;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_READ  = 2'h1,
    ST_CLEAR = 2'h3,
    ST_WRITE = 2'h2
  } acc_state_t;

endpackage : mgmt_access_pkg

// file: core/mgmt_register_access.sv
// Notes on behaviour
// R1 - Reset, low-power and interrupt discrete signals
// R2 - Discrete signals logical; pin polarity separate
// R3 - 256 bytes: lower 00h-7Fh, upper 80h-FFh
// R4 - Reads return one to eight bytes
// R5 - Read without address starts at current pointer
// R6 - Clear-on-read effects may finish after read
// R7 - Reads may be rejected, distinctly; retry allowed
// R8 - Write stores up to eight consecutive bytes
// R9 - Rejected write changes nothing, reports failure
// R10 - Host never mixes volatile and non-volatile writes
// R11 - Readiness probe answers without data
// R12 - Host schedules, retries or probes around rejection
// R13 - Hold-off after write only as needed, bounded
// R14 - Single byte read-back returns written value
// R15 - Multi-byte read-back returns written subrange
// R16 - Hold later access off until read-back holds
// R17 - Write effects need not align with write end
// R18 - Single-byte reads and writes are atomic
// R19 - Size-matched scalar reads never updated mid-read
// R20 - Other multi-byte reads need not be coherent
// R21 - Multi-byte writes need not be atomic
// R22 - Custom interrupt sources silent until unmasked
// R23 - Hold-off maximum enforced by releasing counter
`timescale 1ns/10ps
module mgmt_register_access
  import mgmt_access_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        reset_req_pin_i,
  input  wire logic        lowpwr_req_pin_i,
  input  wire logic        req_valid_i,
  input  wire logic [1:0]  req_op_i,
  input  wire logic        req_addr_valid_i,
  input  wire logic [7:0]  req_addr_i,
  input  wire logic [3:0]  req_len_i,
  input  wire logic [63:0] req_wdata_i,
  input  wire logic        int_upd_valid_i,
  input  wire logic [7:0]  int_upd_addr_i,
  input  wire logic [7:0]  int_upd_data_i,
  output logic             int_upd_ready_o,
  output logic             rsp_valid_o,
  output logic             rsp_ok_o,
  output logic             rsp_rejected_o,
  output logic [3:0]       rsp_len_o,
  output logic [63:0]      rsp_data_o,
  output logic             interrupt_pin_o,
  output logic             low_power_mode_o,
  output logic             module_reset_o
);

  typedef struct packed {
    acc_state_t  st;
    logic [7:0]  ptr;
    logic [7:0]  base;
    logic [3:0]  cnt;
    logic [3:0]  len;
    logic        nv_hit;
    logic [63:0] wdata;
    logic [63:0] rdata;
    logic        rsp_valid;
    logic        rsp_ok;
    logic        rsp_rej;
    logic [3:0]  rsp_len;
    logic        upd_ready;
    logic        irq_pin;
    logic        low_power;
    logic        mod_reset;
  } core_t;

  localparam core_t CORE_RESET = '{
    st:        ST_IDLE,
    ptr:       8'h00,
    base:      8'h00,
    cnt:       4'h0,
    len:       4'h0,
    nv_hit:    1'b0,
    wdata:     64'h0,
    rdata:     64'h0,
    rsp_valid: 1'b0,
    rsp_ok:    1'b0,
    rsp_rej:   1'b0,
    rsp_len:   4'h0,
    upd_ready: 1'b1,
    irq_pin:   ~IRQ_ACTIVE,
    low_power: LOW_POWER_RESET,
    mod_reset: 1'b0
  };

  function automatic logic [7:0] addr_at(input logic [7:0] base, input logic [3:0] off);
    addr_at = base + {4'h0, off};
  endfunction : addr_at

  function automatic logic is_flag(input logic [7:0] a);
    is_flag = (a >= FLAG_FIRST) && (a <= FLAG_LAST);
  endfunction : is_flag

  function automatic logic is_upper(input logic [7:0] a);
    is_upper = (a >= UPPER_FIRST);
  endfunction : is_upper

  core_t       r;
  core_t       n;
  logic [7:0]  mem_r [MEM_BYTES];
  logic        mem_we;
  logic [7:0]  mem_wa;
  logic [7:0]  mem_wd;
  logic        rst_req;
  logic        lp_req;
  logic        hold_busy;
  logic        hold_start;
  logic        len_ok;
  logic        upd_take;
  logic        irq_any;
  logic [7:0]  mask_or;
  logic [7:0]  cur_byte;
  logic [7:0]  start_addr;
  logic [7:0]  clr_addr;

  discrete_signal_map u_map (
    .reset_req_pin_i  (reset_req_pin_i),
    .lowpwr_req_pin_i (lowpwr_req_pin_i),
    .reset_req_o      (rst_req),
    .lowpwr_req_o     (lp_req)
  );

  holdoff_timer u_hold (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i && !rst_req),
    .start_i    (hold_start),
    .busy_o     (hold_busy)
  );

  // Mask bytes reset to zero, so every flag source stays quiet until unmasked
  always_comb begin
    irq_any = 1'b0;
    mask_or = 8'h00;
    for (int i = 0; i < FLAG_COUNT; i++) begin
      irq_any = irq_any |
                (|(mem_r[FLAG_FIRST + 8'(i)] & mem_r[MASK_FIRST + 8'(i)])); // see R22
      mask_or = mask_or | mem_r[MASK_FIRST + 8'(i)];
    end
  end

  assign len_ok     = (req_len_i != 4'h0) && (req_len_i <= MAX_LEN); // see R4
  assign start_addr = req_addr_valid_i ? req_addr_i : r.ptr;         // see R5
  assign cur_byte   = mem_r[r.ptr];
  assign clr_addr   = addr_at(r.base, r.cnt);
  // Internal updates only land while idle, so no read or write sees a torn byte range
  assign upd_take   = int_upd_valid_i && r.upd_ready; // see R18 see R19 see R20

  always_comb begin
    n           = r;
    n.rsp_valid = 1'b0;
    n.rsp_ok    = 1'b0;
    n.rsp_rej   = 1'b0;
    mem_we      = 1'b0;
    mem_wa      = r.ptr;
    mem_wd      = MEM_RESET;
    hold_start  = 1'b0;
    unique case (r.st)
      ST_IDLE: begin
        if (upd_take) begin
          mem_we = 1'b1;
          mem_wa = int_upd_addr_i;
          mem_wd = int_upd_data_i;
        end
        if (req_valid_i) begin
          n.rsp_len = 4'h0;
          unique case (req_op_i)
            OP_TEST: begin
              n.rsp_valid = 1'b1; // see R11
              n.rsp_ok    = !hold_busy;
            end
            OP_READ, OP_WRITE: begin
              if (!hold_busy && len_ok) begin
                n.st     = (req_op_i == OP_READ) ? ST_READ : ST_WRITE;
                n.ptr    = (req_op_i == OP_READ) ? start_addr : req_addr_i;
                n.base   = n.ptr;
                n.cnt    = 4'h0;
                n.len    = req_len_i;
                n.nv_hit = 1'b0;
                n.wdata  = req_wdata_i;
                n.rdata  = 64'h0;
              end else begin
                n.rsp_valid = 1'b1; // Distinct reject, no data; see R7 see R9 see R16
                n.rsp_rej   = 1'b1;
              end
            end
            default: begin
              n.rsp_valid = 1'b1;
              n.rsp_rej   = 1'b1;
            end
          endcase
        end
      end
      ST_READ: begin
        n.rdata[{r.cnt[2:0], 3'h0} +: 8] = cur_byte; // see R4
        n.ptr = r.ptr + 8'h01;
        n.cnt = r.cnt + 4'h1;
        if (r.cnt == r.len - 4'h1) begin
          n.rsp_valid = 1'b1;
          n.rsp_ok    = 1'b1;
          n.rsp_len   = r.len;
          n.st        = ST_CLEAR; // Clears run after the answer; see R6
          n.cnt       = 4'h0;
        end
      end
      ST_CLEAR: begin
        // Flags are cleared after the answer went out; an update waiting meanwhile
        // is held by the ready handshake and lands afterwards, so no event is lost
        if (is_flag(clr_addr)) begin
          mem_we = 1'b1; // see R6
          mem_wa = clr_addr;
          mem_wd = MEM_RESET;
        end
        n.cnt = r.cnt + 4'h1;
        if (r.cnt == r.len - 4'h1) begin
          n.st  = ST_IDLE;
          n.cnt = 4'h0;
        end
      end
      ST_WRITE: begin
        mem_we   = 1'b1; // Byte by byte, not atomic as a whole; see R8 see R21
        mem_wa   = r.ptr;
        mem_wd   = r.wdata[{r.cnt[2:0], 3'h0} +: 8];
        n.nv_hit = r.nv_hit | is_upper(r.ptr);
        n.ptr    = r.ptr + 8'h01;
        n.cnt    = r.cnt + 4'h1;
        if (r.cnt == r.len - 4'h1) begin
          n.rsp_valid = 1'b1; // see R8
          n.rsp_ok    = 1'b1;
          n.rsp_len   = r.len;
          n.st        = ST_IDLE;
          n.cnt       = 4'h0;
          // Lower memory reads back at once; only upper memory needs a hold-off
          hold_start  = r.nv_hit | is_upper(r.ptr); // see R13 see R16 see R17
        end
      end
    endcase
    n.upd_ready = (n.st == ST_IDLE);
    n.irq_pin   = irq_any ? IRQ_ACTIVE : ~IRQ_ACTIVE; // see R1 see R2
    n.low_power = lp_req;                             // see R1
    n.mod_reset = 1'b0;
    if (rst_req) begin
      n           = CORE_RESET; // see R1
      n.mod_reset = 1'b1;
      n.low_power = lp_req;
      hold_start  = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      r <= CORE_RESET;
    end else begin
      r <= n;
    end
  end

  // Read-back is immediate: a byte written here is what the next read returns
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || rst_req) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem_r[i] <= MEM_RESET; // see R3
      end
    end else if (mem_we) begin
      mem_r[mem_wa] <= mem_wd; // see R14 see R15
    end
  end

  assign int_upd_ready_o  = r.upd_ready;
  assign rsp_valid_o      = r.rsp_valid;
  assign rsp_ok_o         = r.rsp_ok;
  assign rsp_rejected_o   = r.rsp_rej;
  assign rsp_len_o        = r.rsp_len;
  assign rsp_data_o       = r.rdata;
  assign interrupt_pin_o  = r.irq_pin;
  assign low_power_mode_o = r.low_power;
  assign module_reset_o   = r.mod_reset;

  // Counts busy cycles, so the bound needs no long repetition; saturates if stuck
  logic [7:0] busy_cnt_r;

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      busy_cnt_r <= 8'h00;
    end else if (hold_busy) begin
      busy_cnt_r <= (busy_cnt_r == 8'hff) ? busy_cnt_r : busy_cnt_r + 8'h01;
    end else begin
      busy_cnt_r <= 8'h00;
    end
  end

  a_holdoff_bounded: assert property ( // see R13
    @(posedge core_clk_i) disable iff (!resetn_i)
    busy_cnt_r <= 8'(HOLDOFF_CYC))
    else $error("hold-off lasted longer than its maximum");

  a_busy_rejects: assert property ( // see R7
    @(posedge core_clk_i) disable iff (!resetn_i || rst_req)
    (r.st == ST_IDLE && req_valid_i && req_op_i != OP_TEST && hold_busy)
      |=> (rsp_valid_o && rsp_rejected_o && !rsp_ok_o))
    else $error("access during hold-off was not rejected");

  a_reject_no_write: assert property ( // see R9
    @(posedge core_clk_i) disable iff (!resetn_i || rst_req)
    (r.st == ST_IDLE && hold_busy) |=> (r.st != ST_WRITE && !mem_we || upd_take))
    else $error("write started while held off");

  a_test_answer: assert property ( // see R11
    @(posedge core_clk_i) disable iff (!resetn_i || rst_req)
    (r.st == ST_IDLE && req_valid_i && req_op_i == OP_TEST)
      |=> (rsp_valid_o && !rsp_rejected_o && rsp_ok_o == !$past(hold_busy)))
    else $error("readiness probe answered wrongly");

  a_write_timing: assert property ( // see R8
    @(posedge core_clk_i) disable iff (!resetn_i || rst_req)
    (r.st == ST_IDLE && req_valid_i && req_op_i == OP_WRITE && !hold_busy
     && req_len_i == 4'h2)
      |=> !rsp_valid_o ##1 !rsp_valid_o ##1 (rsp_valid_o && rsp_ok_o && rsp_len_o == 4'h2))
    else $error("two-byte write answered at the wrong cycle");

  a_readback_byte: assert property ( // see R14
    @(posedge core_clk_i) disable iff (!resetn_i || rst_req)
    (r.st == ST_WRITE) |=> (mem_r[$past(r.ptr)] == $past(mem_wd)))
    else $error("written byte does not read back");

  a_no_midread_update: assert property ( // see R19
    @(posedge core_clk_i) disable iff (!resetn_i || rst_req)
    (r.st == ST_READ || r.st == ST_WRITE) |-> (!upd_take && !int_upd_ready_o))
    else $error("internal update during an access");

  a_read_from_pointer: assert property ( // see R5
    @(posedge core_clk_i) disable iff (!resetn_i || rst_req)
    (r.st == ST_IDLE && req_valid_i && req_op_i == OP_READ && !req_addr_valid_i
     && !hold_busy && len_ok)
      |=> (r.st == ST_READ && r.base == $past(r.ptr)))
    else $error("addressless read did not start at the current pointer");

  a_clear_after_read: assert property ( // see R6
    @(posedge core_clk_i) disable iff (!resetn_i || rst_req)
    (r.st == ST_READ && r.cnt == r.len - 4'h1)
      |=> (rsp_valid_o && rsp_ok_o && r.st == ST_CLEAR))
    else $error("read did not answer before clearing");

  a_masked_silent: assert property ( // see R22
    @(posedge core_clk_i) disable iff (!resetn_i || rst_req)
    (mask_or == 8'h00) |=> (interrupt_pin_o == ~IRQ_ACTIVE))
    else $error("interrupt raised with all masks clear");

  a_read_length: assert property ( // see R4
    @(posedge core_clk_i) disable iff (!resetn_i)
    (rsp_valid_o && rsp_ok_o) |-> (rsp_len_o <= MAX_LEN))
    else $error("answer longer than eight bytes");

endmodule : mgmt_register_access

// file: verif/host_model.sv
`timescale 1ns/10ps
module host_model
  import mgmt_access_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rsp_valid_i,
  input  wire logic        idle_i,
  output logic             req_valid_o,
  output logic [1:0]       req_op_o,
  output logic             req_addr_valid_o,
  output logic [7:0]       req_addr_o,
  output logic [3:0]       req_len_o,
  output logic [63:0]      req_wdata_o
);
  int lost = 0;

  initial begin
    req_valid_o      = 1'b0;
    req_op_o         = OP_TEST;
    req_addr_valid_o = 1'b0;
    req_addr_o       = 8'h00;
    req_len_o        = 4'h0;
    req_wdata_o      = 64'h0;
  end

  // Entered just after a rising edge; leaves when the next request may start
  task automatic access(input logic [1:0] op, input logic av, input logic [7:0] a,
                        input logic [3:0] n, input logic [63:0] d);
    int k;
    k                = 0;
    req_valid_o      = 1'b1;
    req_op_o         = op;
    req_addr_valid_o = av;
    req_addr_o       = a;
    req_len_o        = n;
    req_wdata_o      = d;
    @(posedge core_clk_i);
    #1;
    // Released fields carry garbage so a late sample cannot pass by luck
    req_valid_o = 1'b0;
    req_addr_o  = ~a;
    req_wdata_o = ~d;
    while (rsp_valid_i !== 1'b1 && k < 20) begin
      @(posedge core_clk_i);
      #1;
      k++;
    end
    // One cycle past the answer, then wait out any clear phase
    do begin
      @(posedge core_clk_i);
      #1;
      k++;
    end while (idle_i !== 1'b1 && k < 40);
    if (k >= 40) lost++;
  endtask : access
endmodule : host_model

// file: verif/tb.sv
`timescale 1ns/10ps
module tb;
  import mgmt_access_pkg::*;

  typedef struct packed {
    logic        ok;
    logic        rej;
    logic [3:0]  len;
    logic        chk;
    logic [63:0] data;
  } exp_t;

  localparam logic IRQ_IDLE = ~IRQ_ACTIVE;

  logic        core_clk_i       = 1'b0;
  logic        resetn_i         = 1'b0;
  logic        reset_req_pin_i  = ~RESET_REQ_ACTIVE;
  logic        lowpwr_req_pin_i = LOWPWR_REQ_ACTIVE;
  logic        upd_valid        = 1'b0;
  logic [7:0]  upd_addr         = 8'h00;
  logic [7:0]  upd_data         = 8'h00;
  logic        req_valid, req_addr_valid, int_upd_ready_o, rsp_valid_o, rsp_ok_o;
  logic        rsp_rejected_o, interrupt_pin_o, low_power_mode_o, module_reset_o;
  logic [1:0]  req_op;
  logic [7:0]  req_addr;
  logic [3:0]  req_len, rsp_len_o;
  logic [63:0] req_wdata, rsp_data_o;
  int          num_errors = 0;
  int          cmp_count  = 0;
  logic [7:0]  ref_mem [256];
  logic [7:0]  ptr       = 8'h00;
  logic [31:0] rnd_state = 32'h1da9;
  exp_t        expq [$];

  always #25 core_clk_i = ~core_clk_i;

  mgmt_register_access i_dut (
    .core_clk_i       (core_clk_i),
    .resetn_i         (resetn_i),
    .reset_req_pin_i  (reset_req_pin_i),
    .lowpwr_req_pin_i (lowpwr_req_pin_i),
    .req_valid_i      (req_valid),
    .req_op_i         (req_op),
    .req_addr_valid_i (req_addr_valid),
    .req_addr_i       (req_addr),
    .req_len_i        (req_len),
    .req_wdata_i      (req_wdata),
    .int_upd_valid_i  (upd_valid),
    .int_upd_addr_i   (upd_addr),
    .int_upd_data_i   (upd_data),
    .int_upd_ready_o  (int_upd_ready_o),
    .rsp_valid_o      (rsp_valid_o),
    .rsp_ok_o         (rsp_ok_o),
    .rsp_rejected_o   (rsp_rejected_o),
    .rsp_len_o        (rsp_len_o),
    .rsp_data_o       (rsp_data_o),
    .interrupt_pin_o  (interrupt_pin_o),
    .low_power_mode_o (low_power_mode_o),
    .module_reset_o   (module_reset_o)
  );

  host_model i_host (
    .core_clk_i       (core_clk_i),
    .rsp_valid_i      (rsp_valid_o),
    .idle_i           (int_upd_ready_o),
    .req_valid_o      (req_valid),
    .req_op_o         (req_op),
    .req_addr_valid_o (req_addr_valid),
    .req_addr_o       (req_addr),
    .req_len_o        (req_len),
    .req_wdata_o      (req_wdata)
  );

  function automatic logic [31:0] rnd_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : rnd_next

  task automatic chk(input logic [63:0] got, input logic [63:0] want, input string msg);
    cmp_count++;
    if (got !== want) begin
      $display("[ERR] %0t %s", $time, msg);
      num_errors++;
    end
  endtask : chk

  task automatic summarize();
    if (expq.size() != 0 || i_host.lost != 0) chk(64'h1, 64'h0, "answers missing");
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : cyc

  task automatic ans(input logic [1:0] op, input logic [7:0] a, input logic [3:0] n,
                     input logic ok);
    exp_t e;
    e     = '0;
    e.ok  = ok;
    e.rej = !ok && op != OP_TEST;
    expq.push_back(e);
    i_host.access(op, 1'b1, a, n, '1);
  endtask : ans

  task automatic rd(input logic av, input logic [7:0] a, input logic [3:0] n);
    exp_t       e;
    logic [7:0] s;
    s     = av ? a : ptr;
    e     = '0;
    e.ok  = 1'b1;
    e.len = n;
    e.chk = 1'b1;
    for (int k = 0; k < n; k++) e.data[8*k +: 8] = ref_mem[8'(s + k)];
    expq.push_back(e);
    i_host.access(OP_READ, av, a, n, 64'h0);
    ptr = 8'(s + n);
    // Flags may clear late, so the model drops them only after the access
    for (int k = 0; k < n; k++) begin
      if (8'(s + k) inside {[FLAG_FIRST:FLAG_LAST]}) ref_mem[8'(s + k)] = 8'h00;
    end
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [3:0] n, input logic [63:0] d);
    exp_t e;
    e     = '0;
    e.ok  = 1'b1;
    e.len = n;
    for (int k = 0; k < n; k++) ref_mem[8'(a + k)] = d[8*k +: 8];
    ptr = 8'(a + n);
    expq.push_back(e);
    i_host.access(OP_WRITE, 1'b1, a, n, d);
  endtask : wr

  task automatic upd(input logic [7:0] a, input logic [7:0] d);
    int k;
    k         = 0;
    upd_valid = 1'b1;
    upd_addr  = a;
    upd_data  = d;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (int_upd_ready_o !== 1'b1 && k < 40);
    #1;
    upd_valid  = 1'b0;
    upd_addr   = ~a;
    upd_data   = ~d;
    ref_mem[a] = d;
    if (k >= 40) chk(64'h1, 64'h0, "update stuck");
  endtask : upd

  always @(posedge core_clk_i) begin : watch_rsp
    exp_t e;
    if (rsp_valid_o === 1'b1) begin
      e = expq.size() != 0 ? expq.pop_front() : exp_t'('1);
      chk(64'({rsp_ok_o, rsp_rejected_o, rsp_len_o}),
          64'({e.ok, e.rej, e.len}), "status");
      if (e.chk) chk(rsp_data_o, e.data, "read data");
    end
  end

  initial begin
    repeat (5000) @(posedge core_clk_i);
    chk(64'h1, 64'h0, "timeout");
    summarize();
  end

  initial begin
    logic [7:0]  a;
    logic [3:0]  n, o;
    logic [63:0] d;
    foreach (ref_mem[i]) ref_mem[i] = MEM_RESET;
    cyc(10);
    resetn_i = 1'b1;
    chk(64'({int_upd_ready_o, interrupt_pin_o, low_power_mode_o, module_reset_o,
             rsp_valid_o}), 64'h1c, "reset outputs");
    rd(1'b1, 8'hf8, 4'h8);
    ans(OP_READ, 8'h20, 4'h0, 1'b0);
    ans(OP_WRITE, 8'h20, 4'h9, 1'b0);
    ans(2'h3, 8'h20, 4'h1, 1'b0);
    rd(1'b1, 8'h1c, 4'h8);
    repeat (12) begin
      rnd_state = rnd_next(rnd_state);
      a = 8'h20 + 8'(rnd_state[7:0] % 8'h58);
      n = 4'(rnd_state[10:8]) + 4'h1;
      o = 4'(rnd_state[15:12] % n);
      d[31:0] = rnd_next(rnd_state);
      rnd_state = rnd_next(d[31:0]);
      d[63:32] = rnd_state;
      wr(a, n, d);
      rd(1'b1, 8'(a + o), n - o);
    end
    wr(8'h7e, 4'h2, 64'h9e5f);
    rd(1'b1, 8'h7f, 4'h1);
    wr(8'h40, 4'h3, 64'h00a1b2c3);
    ans(OP_TEST, 8'h00, 4'h0, 1'b1);
    rd(1'b0, 8'h00, 4'h2);
    wr(8'hfc, 4'h4, 64'h5a6b7c8d);
    ans(OP_TEST, 8'h00, 4'h0, 1'b0);
    ans(OP_READ, 8'hfc, 4'h4, 1'b0);
    ans(OP_WRITE, 8'h40, 4'h1, 1'b0);
    cyc(HOLDOFF_CYC + 2);
    ans(OP_TEST, 8'h00, 4'h0, 1'b1);
    rd(1'b1, 8'hfd, 4'h2);
    rd(1'b1, 8'h40, 4'h1);
    fork
      rd(1'b1, 8'h50, 4'h8);
      begin
        cyc(1);
        upd(8'h52, 8'h77);
      end
    join
    rd(1'b1, 8'h52, 4'h1);
    upd(FLAG_FIRST, 8'h01);
    cyc(2);
    chk(64'(interrupt_pin_o), 64'(IRQ_IDLE), "irq while masked");
    wr(MASK_FIRST, 4'h1, 64'h01);
    cyc(2);
    chk(64'(interrupt_pin_o), 64'(IRQ_ACTIVE), "irq unmasked");
    rd(1'b1, FLAG_FIRST, 4'h1);
    cyc(3);
    chk(64'(interrupt_pin_o), 64'(IRQ_IDLE), "irq after clear");
    rd(1'b1, FLAG_FIRST, 4'h1);
    lowpwr_req_pin_i = ~LOWPWR_REQ_ACTIVE;
    cyc(2);
    chk(64'(low_power_mode_o), 64'h0, "low power off");
    lowpwr_req_pin_i = LOWPWR_REQ_ACTIVE;
    cyc(2);
    chk(64'(low_power_mode_o), 64'h1, "low power on");
    reset_req_pin_i = RESET_REQ_ACTIVE;
    cyc(2);
    chk(64'(module_reset_o), 64'h1, "reset request");
    reset_req_pin_i = ~RESET_REQ_ACTIVE;
    cyc(2);
    chk(64'(module_reset_o), 64'h0, "reset release");
    foreach (ref_mem[i]) ref_mem[i] = MEM_RESET;
    rd(1'b1, 8'hfc, 4'h4);
    summarize();
  end
endmodule : tb
